// ==== verilog/iox_expander.sv ====
// Purpose: Target logic of a 16-bit two-wire I/O expander with AXI4-Lite side port.
// Assumes: scl/sda and pins are asynchronous and sampled on ref_clk.
// Notes:   No clock stretching; two-wire writes win over same-cycle AXI writes.
//
// Implementation choices: the AXI4-Lite register port and the address map.

`timescale 1ns/1ps

module iox_expander (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addr_sel_0,
  input wire logic addr_sel_1,
  input wire logic addr_sel_2,
  input wire logic [iox_pkg::IOX_PINS-1:0] gpioIn,
  output logic [iox_pkg::IOX_PINS-1:0] gpioOut,
  output logic [iox_pkg::IOX_PINS-1:0] gpioOe,
  output logic changeDetNOut,
  output logic changeDetNOe,
  output logic irq,
  input wire logic [iox_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [iox_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import iox_pkg::*;

  // ==========================================================
  // Input sampling
  logic [4:0] linkS;
  logic [IOX_PINS-1:0] pinS;
  logic sclS;
  logic sdaS;
  logic [6:0] myAddr;

  // Sampling at 200 MHz leaves hundreds of cycles per 400 kHz half period
  iox_sync #(.W(5), .INIT(5'h03)) u_link_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din({addr_sel_2, addr_sel_1, addr_sel_0, sdaIn, scl}),
    .dout(linkS)
  );
  iox_sync #(.W(IOX_PINS), .INIT(16'h0000)) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(gpioIn),
    .dout(pinS)
  );
  assign sclS = linkS[0];
  assign sdaS = linkS[1];
  assign myAddr = {IOX_ADDR_BASE, linkS[4:2]};

  // ==========================================================
  // Register storage
  logic [15:0] outReg_q;
  logic [15:0] polReg_q;
  logic [15:0] cfgReg_q;
  logic [15:0] inLatch_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;

  // Reported input is the live sample, corrected for polarity
  function automatic logic [7:0] regRead(input logic [2:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx[2:1])
      KIND_IN: v = pinS ^ polReg_q;
      KIND_OUT: v = outReg_q;
      KIND_POL: v = polReg_q;
      KIND_CFG: v = cfgReg_q;
      default: v = 16'h0000;
    endcase
    regRead = idx[0] ? v[15:8] : v[7:0];
  endfunction

  // ==========================================================
  // Serial target state machine
  iox_state_t state_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic rw_q;
  logic cmdPhase_q;
  logic masterAck_q;
  logic [2:0] ptr_q;
  logic sdaOe_q;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic i2cWr;
  logic [2:0] i2cWrIdx;
  logic [7:0] i2cWrData;
  logic i2cRd;
  logic [2:0] i2cRdIdx;

  assign sclRise = sclS & ~sclPrev_q;
  assign sclFall = ~sclS & sclPrev_q;
  assign startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopCond = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

  // Byte at the pointer and at its pair partner, ready for the next load
  logic [7:0] rdCur;
  logic [7:0] rdAlt;
  always_comb begin
    rdCur = regRead(ptr_q);
    rdAlt = regRead({ptr_q[2:1], ~ptr_q[0]});
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      cmdPhase_q <= 1'b0;
      masterAck_q <= 1'b0;
      ptr_q <= 3'h0;
      sdaOe_q <= 1'b0;
    end else if (startCond) begin
      state_q <= S_ADDR;
      bitCnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
    end else if (stopCond) begin
      state_q <= S_IDLE;
      sdaOe_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          sdaOe_q <= 1'b0;
        end
        S_ADDR: begin
          if (sclRise && bitCnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            // Only answer our own address; never start a transfer
            if (shift_q[7:1] == myAddr) begin
              sdaOe_q <= 1'b1;
              rw_q <= shift_q[0];
              state_q <= S_ACK_ADDR;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_ACK_ADDR: begin
          if (sclFall) begin
            if (rw_q) begin
              sdaOe_q <= ~rdCur[7];
              shift_q <= {rdCur[6:0], 1'b1};
              bitCnt_q <= 4'h1;
              state_q <= S_RD_BYTE;
            end else begin
              sdaOe_q <= 1'b0;
              bitCnt_q <= 4'h0;
              cmdPhase_q <= 1'b1;
              state_q <= S_WR_BYTE;
            end
          end
        end
        S_WR_BYTE: begin
          if (sclRise && bitCnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            sdaOe_q <= 1'b1;
            state_q <= S_ACK_WR;
            if (cmdPhase_q) begin
              ptr_q <= shift_q[2:0];
              cmdPhase_q <= 1'b0;
            end else begin
              // Pointer flips between the two bytes of a pair
              ptr_q <= {ptr_q[2:1], ~ptr_q[0]};
            end
          end
        end
        S_ACK_WR: begin
          if (sclFall) begin
            sdaOe_q <= 1'b0;
            bitCnt_q <= 4'h0;
            state_q <= S_WR_BYTE;
          end
        end
        S_RD_BYTE: begin
          if (sclFall) begin
            if (bitCnt_q == 4'h8) begin
              sdaOe_q <= 1'b0;
              state_q <= S_ACK_RD;
            end else begin
              sdaOe_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b1};
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        S_ACK_RD: begin
          if (sclRise) begin
            masterAck_q <= ~sdaS;
          end else if (sclFall) begin
            if (masterAck_q) begin
              ptr_q <= {ptr_q[2:1], ~ptr_q[0]};
              sdaOe_q <= ~rdAlt[7];
              shift_q <= {rdAlt[6:0], 1'b1};
              bitCnt_q <= 4'h1;
              state_q <= S_RD_BYTE;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end

  // Side effects of the serial transfer, seen by the register file
  assign i2cWr = (state_q == S_WR_BYTE) && sclFall && (bitCnt_q == 4'h8) && !cmdPhase_q
                 && !startCond && !stopCond;
  assign i2cWrIdx = ptr_q;
  assign i2cWrData = shift_q;
  assign i2cRd = ((state_q == S_ACK_ADDR && rw_q) || (state_q == S_ACK_RD && masterAck_q))
                 && sclFall && !startCond && !stopCond;
  assign i2cRdIdx = (state_q == S_ACK_RD) ? {ptr_q[2:1], ~ptr_q[0]} : ptr_q;

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q;

  // ==========================================================
  // AXI4-Lite slave
  logic awHeld_q;
  logic wHeld_q;
  logic [AXI_AW-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic axiWrGo;
  logic axiRegWr;
  logic axiRd;
  logic axiInRd;
  logic [ST_W-1:0] statusClr;

  assign awready = ~awHeld_q & ~bvalid_q;
  assign wready = ~wHeld_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign axiWrGo = awHeld_q & wHeld_q & ~bvalid_q;
  assign axiRegWr = axiWrGo && awAddr_q[7:5] == OFF_REG_HI && wStrb_q[0];
  assign axiRd = arvalid & ~rvalid_q;
  assign axiInRd = axiRd && araddr[7:5] == OFF_REG_HI && araddr[4:3] == KIND_IN;
  assign statusClr = (axiWrGo && awAddr_q == OFF_STATUS && wStrb_q[0]) ? wData_q[ST_W-1:0]
                     : {ST_W{1'b0}};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (axiWrGo) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awAddr_q[7:5] == OFF_REG_HI || awAddr_q == OFF_STATUS
                    || awAddr_q == OFF_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (axiRd) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      if (araddr[7:5] == OFF_REG_HI) begin
        rdata_q <= {24'h000000, regRead(araddr[4:2])};
      end else if (araddr == OFF_STATUS) begin
        rdata_q <= {29'h0000000, status_q};
      end else if (araddr == OFF_MASK) begin
        rdata_q <= {29'h0000000, mask_q};
      end else if (araddr == OFF_BUSADDR) begin
        rdata_q <= {25'h000000, myAddr};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ==========================================================
  // Register writes; serial port has priority in a tie
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      outReg_q <= RST_OUT;
      polReg_q <= RST_POL;
      cfgReg_q <= RST_CFG;
    end else if (i2cWr || axiRegWr) begin
      case (i2cWr ? i2cWrIdx[2:1] : awAddr_q[4:3])
        KIND_OUT: begin
          if (i2cWr ? i2cWrIdx[0] : awAddr_q[2]) begin
            outReg_q[15:8] <= i2cWr ? i2cWrData : wData_q[7:0];
          end else begin
            outReg_q[7:0] <= i2cWr ? i2cWrData : wData_q[7:0];
          end
        end
        KIND_POL: begin
          if (i2cWr ? i2cWrIdx[0] : awAddr_q[2]) begin
            polReg_q[15:8] <= i2cWr ? i2cWrData : wData_q[7:0];
          end else begin
            polReg_q[7:0] <= i2cWr ? i2cWrData : wData_q[7:0];
          end
        end
        KIND_CFG: begin
          if (i2cWr ? i2cWrIdx[0] : awAddr_q[2]) begin
            cfgReg_q[15:8] <= i2cWr ? i2cWrData : wData_q[7:0];
          end else begin
            cfgReg_q[7:0] <= i2cWr ? i2cWrData : wData_q[7:0];
          end
        end
        default: begin
          // Input register ignores writes
        end
      endcase
    end
  end

  // Reading an input port refreshes its stored value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      inLatch_q <= 16'h0000;
    end else begin
      if ((i2cRd && i2cRdIdx[2:1] == KIND_IN && !i2cRdIdx[0])
          || (axiInRd && !araddr[2])) begin
        inLatch_q[7:0] <= pinS[7:0];
      end
      if ((i2cRd && i2cRdIdx[2:1] == KIND_IN && i2cRdIdx[0])
          || (axiInRd && araddr[2])) begin
        inLatch_q[15:8] <= pinS[15:8];
      end
    end
  end

  assign gpioOut = outReg_q;
  assign gpioOe = ~cfgReg_q;

  // ==========================================================
  // Change detect and interrupt
  logic changeNow;
  logic changeOe_q;
  logic irq_q;
  logic [ST_W-1:0] statusSet;

  // Only pins set as inputs can flag a change
  assign changeNow = |((pinS ^ inLatch_q) & cfgReg_q);
  assign statusSet = {i2cRd, i2cWr, changeNow & ~changeOe_q};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      changeOe_q <= 1'b0;
    end else begin
      changeOe_q <= changeNow;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_q <= {ST_W{1'b0}};
      mask_q <= RST_MASK;
      irq_q <= 1'b0;
    end else begin
      // A new event outweighs a clear in the same cycle
      status_q <= (status_q & ~statusClr) | statusSet;
      if (axiWrGo && awAddr_q == OFF_MASK && wStrb_q[0]) begin
        mask_q <= wData_q[ST_W-1:0];
      end
      irq_q <= |(status_q & mask_q);
    end
  end

  assign changeDetNOut = 1'b0;
  assign changeDetNOe = changeOe_q;
  assign irq = irq_q;

endmodule

// ==== verilog/iox_pkg.sv ====
// Purpose: Shared constants and types of the two-wire 16-bit I/O expander.
// Assumes: 200 MHz ref_clk; registers are bytes, two ports of eight pins.
// Notes:   Command byte indexes 0..7 select the eight byte registers.

package iox_pkg;

  // ==========================================================
  // Geometry
  localparam int IOX_PINS = 16;
  localparam int IOX_PORT_W = 8;

  // ==========================================================
  // Bus address: fixed upper part plus three select pins
  localparam logic [3:0] IOX_ADDR_BASE = 4'h4;

  // ==========================================================
  // Register kinds, command index bits [2:1]; bit 0 picks the port
  localparam logic [1:0] KIND_IN = 2'h0;
  localparam logic [1:0] KIND_OUT = 2'h1;
  localparam logic [1:0] KIND_POL = 2'h2;
  localparam logic [1:0] KIND_CFG = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_OUT = 16'h0000;
  localparam logic [15:0] RST_POL = 16'h0000;
  localparam logic [15:0] RST_CFG = 16'hFFFF;
  localparam logic [2:0] RST_MASK = 3'h0;

  // ==========================================================
  // AXI4-Lite map, byte addresses
  localparam int AXI_AW = 8;
  localparam logic [2:0] OFF_REG_HI = 3'h0;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MASK = 8'h24;
  localparam logic [7:0] OFF_BUSADDR = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Interrupt status bits
  localparam int ST_CHANGE = 0;
  localparam int ST_WRITE = 1;
  localparam int ST_READ = 2;
  localparam int ST_W = 3;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_MIN_HALF_CYC = (CLK_MHZ * 1000 + 2 * SCL_MAX_KHZ - 1) / (2 * SCL_MAX_KHZ);
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // Serial target states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_ACK_ADDR = 7'h04,
    S_WR_BYTE = 7'h08,
    S_ACK_WR = 7'h10,
    S_RD_BYTE = 7'h20,
    S_ACK_RD = 7'h40
  } iox_state_t;

endpackage

// ==== verilog/iox_sync.sv ====
// Purpose: Three-flop input synchroniser with a two-stage agreement filter.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes:   Output changes only when stages two and three agree.

`timescale 1ns/1ps

module iox_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import iox_pkg::*;

  // ==========================================================
  // Per-bit chain
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          s1_q <= INIT[i];
          s2_q <= INIT[i];
          s3_q <= INIT[i];
          out_q <= INIT[i];
        end else begin
          s1_q <= din[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // A lone glitch never reaches both later stages
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign dout[i] = out_q;
    end
  endgenerate

endmodule

// ==== tb/iox_expander_sva.sv ====
// Purpose: Port-level checks of the I/O expander
// Assumes: Synchronous active-low reset on ref_clk
// Notes: Bound into every expander instance
`timescale 1ns/1ps
module iox_expander_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [iox_pkg::IOX_PINS-1:0] gpioOe,
  input wire logic changeDetNOut,
  input wire logic changeDetNOe,
  input wire logic irq,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [iox_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  import iox_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Reset and pins
  rst_off_a: assert property (disable iff (1'b0) !rst_n |=> gpioOe == '0
    && !sdaOe && !changeDetNOe && !irq && !bvalid && !rvalid) else $error("reset state bad");
  od_low_a: assert property (sdaOut == 1'b0 && changeDetNOut == 1'b0)
    else $error("open-drain level driven high");
  // Data may only move while the clock is low, else it reads as START or STOP
  sda_lowscl_a: assert property ($changed(sdaOe) |-> !scl)
    else $error("sda moved with scl high");
  dir_change_a: assert property ($changed(gpioOe) |-> !scl || $rose(bvalid))
    else $error("direction changed without a write");
  // ==========================================================
  // Register port
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer not held");
  rd_refuse_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
  rd_unmap_a: assert property (arvalid && arready && araddr > OFF_BUSADDR |=>
    rresp == RESP_SLVERR && rdata == '0) else $error("unmapped read not refused");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |=>
    !awready && !wready ##1 bvalid) else $error("write answer late");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer not held");
  cover property ($rose(changeDetNOe));
  cover property ($rose(irq));
  cover property ($rose(sdaOe));
endmodule
bind iox_expander iox_expander_sva chk (.ref_clk(ref_clk), .rst_n(rst_n), .scl(scl),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .gpioOe(gpioOe), .changeDetNOut(changeDetNOut),
  .changeDetNOe(changeDetNOe), .irq(irq), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready));

// ==== tb/iox_host.sv ====
// Purpose: Behavioural two-wire bus master for the expander bench
// Assumes: SDA has a pull-up outside; sdaPull high pulls it low
// Notes: SCL stands high between frames
`timescale 1ns/1ps
module iox_host (
  output logic scl,
  output logic sdaPull,
  input wire logic sda
);
  // Quarter-bit step: 2.6 us bits stay below the bus clock limit
  localparam time HQ = 650;
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic bit_out(input logic v);
    sdaPull = ~v;
    #(HQ) scl = 1'b1;
    #(2*HQ) scl = 1'b0;
    #(HQ);
  endtask
  task automatic bit_in(output logic v);
    sdaPull = 1'b0;
    #(HQ) scl = 1'b1;
    #(HQ) v = sda;
    #(HQ) scl = 1'b0;
    #(HQ);
  endtask
  task automatic start();
    sdaPull = 1'b1;
    #(HQ) scl = 1'b0;
    #(HQ);
  endtask
  task automatic rstart();
    sdaPull = 1'b0;
    #(HQ) scl = 1'b1;
    #(HQ) sdaPull = 1'b1;
    #(HQ) scl = 1'b0;
    #(HQ);
  endtask
  task automatic stop();
    sdaPull = 1'b1;
    #(HQ) scl = 1'b1;
    #(HQ) sdaPull = 1'b0;
    #(2*HQ);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(nack);
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench of the I/O expander
// Assumes: 200 MHz ref_clk, behavioural bus master
// Notes: Read and write answers are compared from queues
`timescale 1ns/1ps
module tb_top;
  import iox_pkg::*;
  logic ref_clk, rst_n, sda, sdaPull, scl, sdaOut, sdaOe, chgNOut, chgNOe, irq, ack;
  logic [2:0] addrSel;
  logic [15:0] pinDrv, gpioIn, gpioOut, gpioOe, oeX, inX;
  logic [7:0] awaddr, araddr, b, dHi, o0, o1;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int failures, numChecks, seed;
  // ==========================================================
  // Wires: pull-ups on SDA, pins read back what drives them
  assign sda = ~(sdaPull | sdaOe);
  assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & pinDrv);
  iox_host host (.scl(scl), .sdaPull(sdaPull), .sda(sda));
  iox_expander DUT (.ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_sel_0(addrSel[0]), .addr_sel_1(addrSel[1]),
    .addr_sel_2(addrSel[2]), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .changeDetNOut(chgNOut), .changeDetNOe(chgNOe), .irq(irq), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Ready is sampled at the falling edge, where it has settled for the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aOk, wOk;
    int n;
    bq.push_back(er);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      aOk = awvalid && awready;
      wOk = wvalid && wready;
      @(posedge ref_clk);
      if (aOk) awvalid <= 1'b0;
      if (wOk) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      failures++;
      final_report();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic aOk;
    int n;
    rq.push_back({er, exp});
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      aOk = arvalid && arready;
      @(posedge ref_clk);
      if (aOk) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) begin
      failures++;
      final_report();
    end
  endtask
  always @(negedge ref_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("rdata", rdata, rq[0][31:0]);
      chk("rresp", 32'(rresp), 32'(rq[0][33:32]));
      void'(rq.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk("bresp", 32'(bresp), 32'(bq.pop_front()));
    end
  end
  task automatic sw(input logic [7:0] d, input logic e);
    host.wbyte(d, ack);
    chk("ack", 32'(ack), 32'(e));
  endtask
  task automatic settle();
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic flip0();
    @(posedge ref_clk);
    pinDrv[0] <= ~pinDrv[0];
    settle();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    seed = 40;
    failures = 0;
    numChecks = 0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    addrSel = 3'($random(seed));
    pinDrv = 16'($random(seed));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk("oe", 32'(gpioOe), 32'h0);
    chk("out", 32'(gpioOut), 32'h0);
    chk("chg", 32'(chgNOe), 32'h0);
    axi_rd(8'h18, 32'hFF, RESP_OKAY);
    axi_rd(8'h1C, 32'hFF, RESP_OKAY);
    axi_rd(8'h08, 32'h0, RESP_OKAY);
    axi_rd(8'h10, 32'h0, RESP_OKAY);
    axi_rd(OFF_BUSADDR, 32'({IOX_ADDR_BASE, addrSel}), RESP_OKAY);
    axi_rd(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(8'h40, 32'hFF, RESP_SLVERR);
    // Link steps are whole clock periods: start on a fall so no pin moves on a rise
    @(negedge ref_clk);
    host.start();
    sw({IOX_ADDR_BASE, ~addrSel, 1'b0}, 1'b1);
    host.stop();
    dHi = 8'($random(seed));
    o0 = 8'($random(seed));
    o1 = 8'($random(seed));
    host.start();
    sw({IOX_ADDR_BASE, addrSel, 1'b0}, 1'b0);
    sw(8'h06, 1'b0);
    sw(8'h0F, 1'b0);
    sw(dHi, 1'b0);
    host.rstart();
    sw({IOX_ADDR_BASE, addrSel, 1'b0}, 1'b0);
    sw(8'h02, 1'b0);
    sw(o0, 1'b0);
    sw(o1, 1'b0);
    host.stop();
    settle();
    oeX = {~dHi, 8'hF0};
    inX = (oeX & {o1, o0}) | (~oeX & pinDrv);
    chk("oe", 32'(gpioOe), 32'(oeX));
    chk("out", 32'(gpioOut), 32'({o1, o0}));
    axi_wr(OFF_MASK, 32'h1, RESP_OKAY);
    axi_wr(8'h10, 32'hFF, RESP_OKAY);
    axi_rd(8'h00, {24'h000000, ~inX[7:0]}, RESP_OKAY);
    axi_rd(8'h04, 32'(inX[15:8]), RESP_OKAY);
    axi_wr(OFF_STATUS, 32'h7, RESP_OKAY);
    settle();
    chk("chg", 32'(chgNOe), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    flip0();
    chk("chg", 32'(chgNOe), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    flip0();
    chk("chg", 32'(chgNOe), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    axi_wr(OFF_MASK, 32'h0, RESP_OKAY);
    flip0();
    chk("chg", 32'(chgNOe), 32'h1);
    chk("irq", 32'(irq), 32'h0);
    axi_rd(8'h00, {24'h000000, ~(inX[7:0] ^ 8'h01)}, RESP_OKAY);
    axi_wr(OFF_STATUS, 32'h1, RESP_OKAY);
    axi_wr(OFF_MASK, 32'h1, RESP_OKAY);
    settle();
    chk("chg", 32'(chgNOe), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    host.start();
    sw({IOX_ADDR_BASE, addrSel, 1'b0}, 1'b0);
    sw(8'h06, 1'b0);
    host.rstart();
    sw({IOX_ADDR_BASE, addrSel, 1'b1}, 1'b0);
    host.rbyte(1'b1, b);
    host.stop();
    chk("serial rd", 32'(b), 32'h0F);
    // Only the serial byte load has happened since the last clear
    axi_rd(OFF_STATUS, 32'h4, RESP_OKAY);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk("oe", 32'(gpioOe), 32'h0);
    chk("out", 32'(gpioOut), 32'h0);
    axi_rd(8'h1C, 32'hFF, RESP_OKAY);
    final_report();
  end
endmodule
